// file: src/itd_core_decoder.sv
// Purpose: Decodes transfer, bit and branch opcodes into length, cycles, targets
// Assumes: Operand bytes and datapath flags are valid with instValid
// Notes:   Opcodes outside these groups decode as unknown, one byte, one cycle
//
// How it works
// - Rotate right, rotate via carry and nibble swap: one byte, one cycle.
// - Direct to direct move: three bytes, three cycles.
// - Immediate load of data_pointer: three bytes, three cycles.
// - Both code_byte_read forms: one byte, three cycles.
// - All four external_data_move forms: one byte, three cycles.
// - Stack push and pop of a direct byte: two bytes, two cycles.
// - Accumulator store to indirect RAM: one byte, two cycles.
// - low_nibble_exchange swaps bits 3..0 only; one byte, two cycles.
// - Carry-only ops one byte one cycle; direct bit ops two and two.
// - Carry jumps: two bytes, two cycles not taken, three taken.
// - Bit jumps: three bytes, three cycles not taken, four taken.
// - short_relative_jump: two bytes, three cycles.
// - Accumulator zero jumps: two bytes, two or three cycles.
// - compare_jump_unequal: three/four cycles, indirect form four/five.
// - decrement_jump_nonzero: register two/three, direct byte three/four.
// - Relative offset is signed, added to next instruction address.
// - page_target replaces low eleven bits of next instruction address.
// - full_target reaches any address of the 64K space.
// - Direct address below 0x80 is RAM, 0x80 and above is special_function_register.
// - Indirect address comes from R0 or R1 of the active bank.
// - Register operands select R0..R7 within the active bank.
// - Spare opcode 0xA5 behaves exactly as no_operation.
// - Not-taken conditional branches finish one cycle sooner than taken.
`timescale 1ns/100ps
module itd_core_decoder
  import itd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instValid,
  output logic             instReady,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operandA,
  input  wire logic [7:0]  operandB,
  input  wire logic [15:0] instPc,
  input  wire logic [1:0]  bankSel,
  input  wire logic        carryIn,
  input  wire logic [7:0]  accIn,
  input  wire logic [7:0]  ramIn,
  input  wire logic [15:0] dptrIn,
  input  wire logic        bitIn,
  input  wire logic        cmpUnequal,
  input  wire logic        decNonzero,
  output logic             execDone,
  output logic             instKnown,
  output logic [1:0]       lenOut,
  output logic [2:0]       cyclesOut,
  output logic             branchTaken,
  output logic             pcRedirect,
  output logic             isReturn,
  output logic [15:0]      pcTarget,
  output logic [15:0]      nextPc,
  output logic [7:0]       directAddr,
  output logic             directIsSfr,
  output logic [4:0]       regAddr,
  output logic [4:0]       ptrRegAddr,
  output logic [7:0]       accOut,
  output logic [7:0]       ramOut,
  output logic             carryOut
);

  // ----------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------
  logic [3:0] hi;
  logic       rnForm, indForm;
  logic       g11, g12, g13, g15, g22, g23, gC2, g33, g34, gC3, gC4;
  logic       carryOnly, bitOp, pageForm, farForm, isCond, condTrue, accept;
  logic       isRet, isRrc, isRr, isSwap, isXchd;

  assign hi      = opcode[7:4];
  assign rnForm  = opcode[3];
  assign indForm = (opcode[3:1] == IND_LOW);
  assign isRr    = (opcode == OP_RR);
  assign isRrc   = (opcode == OP_RRC);
  assign isSwap  = (opcode == OP_SWAP);
  assign isXchd  = indForm & (hi == HI_LOW_NIBBLE_EXCHANGE);
  assign isRet   = (opcode == OP_RET) | (opcode == OP_RETI);

  assign carryOnly = (opcode == OP_CLR_C) | (opcode == OP_SETB_C) | (opcode == OP_CPL_C);
  assign bitOp     = (opcode == OP_CLR_BIT) | (opcode == OP_SETB_BIT)
                   | (opcode == OP_CPL_BIT) | (opcode == OP_ANL_C_B)
                   | (opcode == OP_ANL_C_NB) | (opcode == OP_ORL_C_B)
                   | (opcode == OP_ORL_C_NB) | (opcode == OP_MOV_C_B)
                   | (opcode == OP_MOV_B_C);

  // spare opcode joins the no-operation class
  assign g11 = isRr | isRrc | isSwap | carryOnly
             | (opcode == OP_NOP) | (opcode == OP_SPARE_NOP)
             | (rnForm & ((hi == HI_MOV_A_R) | (hi == HI_MOV_R_A) | (hi == HI_XCH)));
  // store to indirect RAM costs an extra cycle
  // nibble exchange, one byte two cycles
  assign g12 = indForm & ((hi == HI_MOV_A_R) | (hi == HI_MOV_R_A)
                        | (hi == HI_XCH) | (hi == HI_LOW_NIBBLE_EXCHANGE));
  assign g13 = (opcode == OP_CODE_DATA_POINTER) | (opcode == OP_CODE_PC)
             | (opcode == OP_XRD_DATA_POINTER) | (opcode == OP_XWR_DATA_POINTER)
             | (opcode[7:1] == OP_XRD_R0[7:1]) | (opcode[7:1] == OP_XWR_R0[7:1])
             | (opcode == OP_JMP_IND);
  assign g15 = isRet;
  assign g22 = (opcode == OP_MOV_A_D) | (opcode == OP_MOV_A_IMM)
             | (opcode == OP_MOV_D_A) | (opcode == OP_PUSH)
             | (opcode == OP_POP) | (opcode == OP_XCH_D) | bitOp
             | ((rnForm | indForm) & ((hi == HI_MOV_R_D) | (hi == HI_MOV_R_I)
                                    | (hi == HI_MOV_D_R)));
  assign pageForm = (opcode[3:0] == LO_PAGE);
  assign g23      = pageForm | (opcode == OP_SHORT_JMP);
  assign gC2 = (opcode == OP_JC) | (opcode == OP_JNC) | (opcode == OP_JZ)
             | (opcode == OP_JNZ) | (rnForm & (hi == HI_LOW_NIBBLE_EXCHANGE));
  assign g33 = (opcode == OP_MOV_D_D) | (opcode == OP_MOV_D_IMM) | (opcode == OP_LOAD_DATA_POINTER);
  assign farForm = (opcode == OP_FAR_CALL) | (opcode == OP_FAR_JUMP);
  assign g34     = farForm;
  // bit jumps, direct decrement jump, compare jumps in accumulator and register forms
  assign gC3 = (opcode == OP_JB) | (opcode == OP_JNB) | (opcode == OP_CMP_A_D)
             | (opcode == OP_CMP_A_IMM) | (opcode == OP_DEC_D_J)
             | (rnForm & (hi == HI_CMP_R));
  assign gC4 = indForm & (hi == HI_CMP_R);

  // ----------------------------------------------------------------
  // Length, cycles, branch decision
  // ----------------------------------------------------------------
  logic       knownNxt, takenNxt, redirectNxt;
  logic [1:0] lenNxt;
  logic [2:0] baseCyc, cycNxt;
  assign knownNxt = g11 | g12 | g13 | g15 | g22 | g23 | gC2 | g33 | g34 | gC3 | gC4;
  assign lenNxt   = (g22 | g23 | gC2)             ? LEN2 :
                    (g33 | g34 | gC3 | gC4)       ? LEN3 : LEN1;
  assign baseCyc  = (g12 | g22 | gC2)             ? CYC2 :
                    (g13 | g23 | g33 | gC3)       ? CYC3 :
                    (g34 | gC4)                   ? CYC4 :
                    g15                           ? CYC5 : CYC1;
  assign isCond   = gC2 | gC3 | gC4;
  assign condTrue = (opcode == OP_JC)  ?  carryIn :
                    (opcode == OP_JNC) ? ~carryIn :
                    (opcode == OP_JB)  ?  bitIn :
                    (opcode == OP_JNB) ? ~bitIn :
                    (opcode == OP_JZ)  ? (accIn == RST_BYTE) :
                    (opcode == OP_JNZ) ? (accIn != RST_BYTE) :
                    (hi == HI_CMP_R)   ? cmpUnequal : decNonzero;
  // taken branch adds the one extra cycle
  assign cycNxt      = baseCyc + {2'd0, isCond & condTrue};
  assign takenNxt    = isCond & condTrue;
  assign redirectNxt = takenNxt | g23 | farForm | isRet | (opcode == OP_JMP_IND);

  // ----------------------------------------------------------------
  // Targets
  // ----------------------------------------------------------------
  itd_target_if tgt ();
  assign tgt.pc       = instPc;
  assign tgt.len      = lenNxt;
  assign tgt.relByte  = (lenNxt == LEN3) ? operandB : operandA;
  assign tgt.pageHigh = opcode[7:5];
  assign tgt.byteA    = operandA;
  assign tgt.byteB    = operandB;
  assign tgt.data_pointer     = dptrIn;
  assign tgt.acc      = accIn;
  itd_target_calc u_calc (
    .tgt (tgt.calc)
  );
  logic [15:0] targetNxt;
  // Return target lives on the stack, so none is produced here
  assign targetNxt = (isCond | (opcode == OP_SHORT_JMP)) ? tgt.relTarget :
                     pageForm                           ? tgt.pageTarget :
                     farForm                            ? tgt.fullTarget :
                     (opcode == OP_JMP_IND)             ? tgt.indTarget : RST_WORD;

  // ----------------------------------------------------------------
  // Operand addressing and small results
  // ----------------------------------------------------------------
  logic [4:0] regAddrNxt, ptrAddrNxt;
  logic [7:0] accNxt, ramNxt;
  logic       carryNxt;
  assign regAddrNxt = {bankSel, opcode[2:0]};
  // only R0 or R1 hold the pointer
  assign ptrAddrNxt = {bankSel, 2'b00, opcode[0]};

  // only the low nibbles trade places
  assign accNxt = isRr   ? {accIn[0], accIn[7:1]} :
                  isRrc  ? {carryIn, accIn[7:1]} :
                  isSwap ? {accIn[3:0], accIn[7:4]} :
                  isXchd ? {accIn[7:4], ramIn[3:0]} : accIn;
  assign ramNxt = isXchd ? {ramIn[7:4], accIn[3:0]} : ramIn;

  assign carryNxt = isRrc                     ? accIn[0] :
                    (opcode == OP_CLR_C)      ? 1'b0 :
                    (opcode == OP_SETB_C)     ? 1'b1 :
                    (opcode == OP_CPL_C)      ? ~carryIn :
                    (opcode == OP_ANL_C_B)    ? (carryIn & bitIn) :
                    (opcode == OP_ANL_C_NB)   ? (carryIn & ~bitIn) :
                    (opcode == OP_ORL_C_B)    ? (carryIn | bitIn) :
                    (opcode == OP_ORL_C_NB)   ? (carryIn | ~bitIn) :
                    (opcode == OP_MOV_C_B)    ? bitIn : carryIn;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  itd_state_e state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic       done_nxt;
  assign instReady = (state_r == ITD_IDLE);
  assign accept    = instValid & instReady;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    case (state_r)
      ITD_IDLE:
      begin
        if (accept)
        begin
          cnt_nxt = cycNxt - CYC1;
          if (cycNxt == CYC1)
            done_nxt = 1'b1;
          else
            state_nxt = ITD_EXEC;
        end
      end
      ITD_EXEC:
      begin
        cnt_nxt = cnt_r - CYC1;
        if (cnt_r == CYC1)
        begin
          done_nxt  = 1'b1;
          state_nxt = ITD_IDLE;
        end
      end
      default:
      begin
        state_nxt = ITD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r  <= ITD_IDLE;
      cnt_r    <= 3'd0;
      execDone <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      execDone <= done_nxt;
    end
  end

  // Results latch at acceptance and hold until the next one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      instKnown   <= 1'b0;
      lenOut      <= 2'd0;
      cyclesOut   <= 3'd0;
      branchTaken <= 1'b0;
      pcRedirect  <= 1'b0;
      isReturn    <= 1'b0;
      pcTarget    <= RST_WORD;
      nextPc      <= RST_WORD;
      directAddr  <= RST_BYTE;
      directIsSfr <= 1'b0;
      regAddr     <= 5'd0;
      ptrRegAddr  <= 5'd0;
      accOut      <= RST_BYTE;
      ramOut      <= RST_BYTE;
      carryOut    <= 1'b0;
    end
    else if (accept)
    begin
      instKnown   <= knownNxt;
      lenOut      <= lenNxt;
      cyclesOut   <= cycNxt;
      branchTaken <= takenNxt;
      pcRedirect  <= redirectNxt;
      isReturn    <= isRet;
      pcTarget    <= targetNxt;
      nextPc      <= tgt.nextPc;
      directAddr  <= operandA;
      // top bit picks the register space
      directIsSfr <= operandA[SFR_BIT];
      regAddr     <= regAddrNxt;
      ptrRegAddr  <= ptrAddrNxt;
      accOut      <= accNxt;
      ramOut      <= ramNxt;
      carryOut    <= carryNxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] accPrev_r, ramPrev_r, opndPrev_r;
  always_ff @(posedge clk)
  begin
    accPrev_r  <= accIn;
    ramPrev_r  <= ramIn;
    opndPrev_r <= operandA;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_two;
    !execDone ##1 execDone;
  endsequence
  sequence s_three;
    !execDone [*2] ##1 execDone;
  endsequence
  sequence s_four;
    !execDone [*3] ##1 execDone;
  endsequence

  a_rot_single: assert property (accept && (isRr || isRrc || isSwap) |=>
    execDone && lenOut == 2'd1 && cyclesOut == 3'd1) else $error("rotate timing wrong");
  a_move_dd: assert property (accept && opcode == OP_MOV_D_D |=>
    s_three ##0 lenOut == 2'd3) else $error("direct move timing wrong");
  a_data_pointer_load: assert property (accept && opcode == OP_LOAD_DATA_POINTER |=>
    s_three ##0 lenOut == 2'd3) else $error("pointer load timing wrong");
  a_code_read: assert property (accept && (opcode == OP_CODE_DATA_POINTER || opcode == OP_CODE_PC)
    |=> s_three ##0 lenOut == 2'd1) else $error("code read timing wrong");
  a_ext_move: assert property (accept && (opcode == OP_XRD_DATA_POINTER || opcode == OP_XWR_DATA_POINTER)
    |=> s_three ##0 lenOut == 2'd1) else $error("external move timing wrong");
  a_stack_op: assert property (accept && (opcode == OP_PUSH || opcode == OP_POP)
    |=> s_two ##0 lenOut == 2'd2) else $error("stack op timing wrong");
  a_ind_store: assert property (accept && indForm && hi == HI_MOV_R_A |=>
    s_two ##0 lenOut == 2'd1) else $error("indirect store timing wrong");
  a_nibble_swap: assert property (accept && isXchd |=>
    accOut == {accPrev_r[7:4], ramPrev_r[3:0]} && ramOut == {ramPrev_r[7:4], accPrev_r[3:0]}
    ##1 execDone) else $error("nibble exchange wrong");
  a_carry_jump: assert property (accept && opcode == OP_JC |=>
    (branchTaken ? cyclesOut == 3'd3 : cyclesOut == 3'd2) && lenOut == 2'd2)
    else $error("carry jump timing wrong");
  a_bit_jump: assert property (accept && opcode == OP_JB && bitIn |=>
    s_four ##0 branchTaken) else $error("taken bit jump timing wrong");
  a_cmp_ind: assert property (accept && gC4 && !cmpUnequal |=>
    s_four ##0 !branchTaken) else $error("indirect compare timing wrong");
  a_cond_faster: assert property (accept && isCond |=>
    cyclesOut == $past(baseCyc) + {2'd0, branchTaken}) else $error("branch cycle gap wrong");
  a_spare_nop: assert property (accept && opcode == OP_SPARE_NOP |=>
    execDone && !pcRedirect && accOut == accPrev_r && instKnown) else $error("spare nop wrong");
  a_sfr_select: assert property (accept |=>
    directIsSfr == opndPrev_r[7]) else $error("direct space select wrong");

endmodule

// file: src/itd_pkg.sv
// Purpose: Shared constants for the instruction timing decoder
// Assumes: One opcode byte plus up to two operand bytes per instruction
// Notes:   Opcode values follow the published binary encoding
package itd_pkg;

  // ----------------------------------------------------------------
  // Single opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_SPARE_NOP = 8'hA5;
  localparam logic [7:0] OP_RR        = 8'h03;
  localparam logic [7:0] OP_RRC       = 8'h13;
  localparam logic [7:0] OP_SWAP      = 8'hC4;
  localparam logic [7:0] OP_MOV_A_D   = 8'hE5;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_D_A   = 8'hF5;
  localparam logic [7:0] OP_MOV_D_D   = 8'h85;
  localparam logic [7:0] OP_MOV_D_IMM = 8'h75;
  localparam logic [7:0] OP_LOAD_DATA_POINTER = 8'h90;
  localparam logic [7:0] OP_CODE_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_CODE_PC   = 8'h83;
  localparam logic [7:0] OP_XRD_R0    = 8'hE2;
  localparam logic [7:0] OP_XWR_R0    = 8'hF2;
  localparam logic [7:0] OP_XRD_DATA_POINTER  = 8'hE0;
  localparam logic [7:0] OP_XWR_DATA_POINTER  = 8'hF0;
  localparam logic [7:0] OP_PUSH      = 8'hC0;
  localparam logic [7:0] OP_POP       = 8'hD0;
  localparam logic [7:0] OP_XCH_D     = 8'hC5;
  localparam logic [7:0] OP_CLR_C     = 8'hC3;
  localparam logic [7:0] OP_SETB_C    = 8'hD3;
  localparam logic [7:0] OP_CPL_C     = 8'hB3;
  localparam logic [7:0] OP_CLR_BIT   = 8'hC2;
  localparam logic [7:0] OP_SETB_BIT  = 8'hD2;
  localparam logic [7:0] OP_CPL_BIT   = 8'hB2;
  localparam logic [7:0] OP_ANL_C_B   = 8'h82;
  localparam logic [7:0] OP_ANL_C_NB  = 8'hB0;
  localparam logic [7:0] OP_ORL_C_B   = 8'h72;
  localparam logic [7:0] OP_ORL_C_NB  = 8'hA0;
  localparam logic [7:0] OP_MOV_C_B   = 8'hA2;
  localparam logic [7:0] OP_MOV_B_C   = 8'h92;
  localparam logic [7:0] OP_JC        = 8'h40;
  localparam logic [7:0] OP_JNC       = 8'h50;
  localparam logic [7:0] OP_JB        = 8'h20;
  localparam logic [7:0] OP_JNB       = 8'h30;
  localparam logic [7:0] OP_JZ        = 8'h60;
  localparam logic [7:0] OP_JNZ       = 8'h70;
  localparam logic [7:0] OP_CMP_A_D   = 8'hB5;
  localparam logic [7:0] OP_CMP_A_IMM = 8'hB4;
  localparam logic [7:0] OP_DEC_D_J   = 8'hD5;
  localparam logic [7:0] OP_FAR_CALL  = 8'h12;
  localparam logic [7:0] OP_FAR_JUMP  = 8'h02;
  localparam logic [7:0] OP_SHORT_JMP = 8'h80;
  localparam logic [7:0] OP_JMP_IND   = 8'h73;
  localparam logic [7:0] OP_RET       = 8'h22;
  localparam logic [7:0] OP_RETI      = 8'h32;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [3:0] HI_MOV_A_R = 4'hE;
  localparam logic [3:0] HI_MOV_R_A = 4'hF;
  localparam logic [3:0] HI_XCH     = 4'hC;
  localparam logic [3:0] HI_LOW_NIBBLE_EXCHANGE    = 4'hD;
  localparam logic [3:0] HI_MOV_R_D = 4'hA;
  localparam logic [3:0] HI_MOV_R_I = 4'h7;
  localparam logic [3:0] HI_MOV_D_R = 4'h8;
  localparam logic [3:0] HI_CMP_R   = 4'hB;
  localparam logic [3:0] LO_PAGE    = 4'h1;
  localparam logic [2:0] IND_LOW    = 3'b011;
  localparam int         SFR_BIT    = 7;

  // ----------------------------------------------------------------
  // Lengths, cycle counts, reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  LEN1 = 2'd1;
  localparam logic [1:0]  LEN2 = 2'd2;
  localparam logic [1:0]  LEN3 = 2'd3;
  localparam logic [2:0]  CYC1 = 3'd1;
  localparam logic [2:0]  CYC2 = 3'd2;
  localparam logic [2:0]  CYC3 = 3'd3;
  localparam logic [2:0]  CYC4 = 3'd4;
  localparam logic [2:0]  CYC5 = 3'd5;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic {ITD_IDLE, ITD_EXEC} itd_state_e;

endpackage

// file: src/itd_target_if.sv
// Purpose: Carries branch target inputs and results between modules
// Assumes: Purely combinational path
// Notes:   calc computes, user supplies operands
`timescale 1ns/100ps
interface itd_target_if;
  import itd_pkg::*;
  logic [15:0] pc;
  logic [1:0]  len;
  logic [7:0]  relByte;
  logic [2:0]  pageHigh;
  logic [7:0]  byteA;
  logic [7:0]  byteB;
  logic [15:0] data_pointer;
  logic [7:0]  acc;
  logic [15:0] nextPc;
  logic [15:0] relTarget;
  logic [15:0] pageTarget;
  logic [15:0] fullTarget;
  logic [15:0] indTarget;
  modport calc (input pc, len, relByte, pageHigh, byteA, byteB, data_pointer, acc,
                output nextPc, relTarget, pageTarget, fullTarget, indTarget);
  modport user (output pc, len, relByte, pageHigh, byteA, byteB, data_pointer, acc,
                input nextPc, relTarget, pageTarget, fullTarget, indTarget);
endinterface

// file: src/itd_target_calc.sv
// Purpose: Branch target arithmetic for the instruction timing decoder
// Assumes: pc is the address of the opcode byte
// Notes:   All targets wrap within the 64K space
`timescale 1ns/100ps
module itd_target_calc
  import itd_pkg::*;
(
  itd_target_if.calc tgt
);

  logic [15:0] relExt;

  // Address of the byte after the instruction
  assign tgt.nextPc     = tgt.pc + {14'd0, tgt.len};
  assign relExt         = {{8{tgt.relByte[7]}}, tgt.relByte};
  assign tgt.relTarget  = tgt.nextPc + relExt;
  // eleven bits replace low part, page kept
  assign tgt.pageTarget = {tgt.nextPc[15:11], tgt.pageHigh, tgt.byteA};
  assign tgt.fullTarget = {tgt.byteA, tgt.byteB};
  assign tgt.indTarget  = tgt.data_pointer + {8'd0, tgt.acc};

endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for itd_core_decoder
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Branch flags and operands are random, so taken and not-taken both occur
`timescale 1ns/100ps
module tb
  import itd_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, instValid, carryIn, bitIn, cmpUnequal, decNonzero;
  logic [7:0]  opcode, operandA, operandB, accIn, ramIn;
  logic [15:0] instPc, dptrIn;
  logic [1:0]  bankSel;
  logic        instReady, execDone, instKnown, branchTaken, pcRedirect, isReturn, directIsSfr;
  logic [1:0]  lenOut;
  logic [2:0]  cyclesOut, cnt;
  logic [15:0] pcTarget, nextPc;
  logic [7:0]  directAddr, accOut, ramOut;
  logic [4:0]  regAddr, ptrRegAddr;
  logic        carryOut;
  logic [34:0] q[$];
  logic [34:0] e;
  logic [53:0] q2[$];
  logic [53:0] e2;
  logic [31:0] seed = 32'h0941_b3d3;
  int          miscompares = 0, checks_done = 0, cycles = 0;
  logic [7:0]  ops[$] = {8'h03, 8'h13, 8'hC4, 8'h85, 8'h90, 8'h93, 8'h83, 8'hE2, 8'hF2,
    8'hE0, 8'hF0, 8'hC0, 8'hD0, 8'hF6, 8'hD6, 8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2, 8'h82,
    8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h40, 8'h50, 8'h20, 8'h30, 8'h60, 8'h70, 8'hB5, 8'hB4,
    8'hBE, 8'hB6, 8'hD8, 8'hD5, 8'h80, 8'h01, 8'h11, 8'h02, 8'h12, 8'h00, 8'hA5, 8'h73,
    8'h22, 8'h32};

  itd_core_decoder DUT (.clk, .rst_n, .instValid, .instReady, .opcode, .operandA, .operandB,
    .instPc, .bankSel, .carryIn, .accIn, .ramIn, .dptrIn, .bitIn, .cmpUnequal, .decNonzero,
    .execDone, .instKnown, .lenOut, .cyclesOut, .branchTaken, .pcRedirect, .isReturn,
    .pcTarget, .nextPc, .directAddr, .directIsSfr, .regAddr, .ptrRegAddr, .accOut, .ramOut,
    .carryOut);

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [8:0] spec(input logic [7:0] op);
    case (op)
      8'h85, 8'h90: return {LEN3, CYC3, 4'h0};
      8'h93, 8'h83, 8'hE2, 8'hF2, 8'hE0, 8'hF0: return {LEN1, CYC3, 4'h0};
      8'hF6, 8'hD6: return {LEN1, CYC2, 4'h0};
      8'h40: return {LEN2, CYC2, 4'h1};
      8'h50: return {LEN2, CYC2, 4'h2};
      8'h20: return {LEN3, CYC3, 4'h3};
      8'h30: return {LEN3, CYC3, 4'h4};
      8'h60: return {LEN2, CYC2, 4'h5};
      8'h70: return {LEN2, CYC2, 4'h6};
      8'hB5, 8'hB4, 8'hBE: return {LEN3, CYC3, 4'h7};
      8'hB6: return {LEN3, CYC4, 4'h7};
      8'hD8: return {LEN2, CYC2, 4'h8};
      8'hD5: return {LEN3, CYC3, 4'h8};
      8'h80: return {LEN2, CYC2, 4'h9};
      8'h01, 8'h11: return {LEN2, CYC2, 4'hA};
      8'h02, 8'h12: return {LEN3, CYC3, 4'hB};
      8'h03, 8'h13, 8'hC4, 8'hC3, 8'hD3, 8'hB3, 8'h00, 8'hA5: return {LEN1, CYC1, 4'h0};
      // Indirect jump and returns always redirect, hence base one below total
      8'h73: return {LEN1, CYC2, 4'hC};
      8'h22, 8'h32: return {LEN1, CYC4, 4'hD};
      default: return {LEN2, CYC2, 4'h0};
    endcase
  endfunction

  task automatic send(input logic [7:0] op);
    logic [8:0]  s;
    logic [31:0] r;
    logic        tk;
    logic [15:0] nx, tg;
    logic [7:0]  off;
    logic        cy;
    logic [7:0]  ax;
    s = spec(op);
    r = rnd();
    opcode = op; operandA = r[7:0]; operandB = r[15:8]; instPc = r[31:16];
    r = rnd();
    carryIn = r[0]; bitIn = r[1]; cmpUnequal = r[2]; decNonzero = r[3]; bankSel = r[5:4];
    accIn = r[6] ? 8'h00 : r[15:8]; ramIn = r[23:16]; dptrIn = r[31:16]; instValid = 1'b1;
    case (s[3:0])
      4'h0: tk = 1'b0;
      4'h1: tk = carryIn;
      4'h2: tk = !carryIn;
      4'h3: tk = bitIn;
      4'h4: tk = !bitIn;
      4'h5: tk = accIn == 8'h00;
      4'h6: tk = accIn != 8'h00;
      4'h7: tk = cmpUnequal;
      4'h8: tk = decNonzero;
      default: tk = 1'b1;
    endcase
    nx = instPc + {14'h0000, s[8:7]};
    off = (s[8:7] == LEN3) ? operandB : operandA;
    tg = (s[3:0] == 4'hA) ? {nx[15:11], op[7:5], operandA} :
         (s[3:0] == 4'hB) ? {operandA, operandB} :
         (s[3:0] == 4'hC) ? dptrIn + {8'h00, accIn} :
         (s[3:0] == 4'hD) ? 16'h0000 : nx + {{8{off[7]}}, off};
    cy = (op == 8'h13) ? accIn[0] : (op == 8'hC3) ? 1'b0 : (op == 8'hD3) ? 1'b1 :
         (op == 8'hB3) ? !carryIn : (op == 8'h82) ? carryIn & bitIn :
         (op == 8'hB0) ? carryIn & !bitIn : (op == 8'h72) ? carryIn | bitIn :
         (op == 8'hA0) ? carryIn | !bitIn : (op == 8'hA2) ? bitIn : carryIn;
    ax = (op == 8'h03) ? {accIn[0], accIn[7:1]} : (op == 8'h13) ? {carryIn, accIn[7:1]} :
         (op == 8'hC4) ? {accIn[3:0], accIn[7:4]} :
         (op == 8'hD6) ? {accIn[7:4], ramIn[3:0]} : accIn;
    while (instReady !== 1'b1) @(posedge clk) #1;
    q.push_back({op == 8'hD6, s[8:7], s[6:4] + 3'(tk), s[6:4] + 3'(tk), tk, operandA[7],
      tk ? tg : 16'h0000, op == 8'hD6 ? {accIn[7:4], ramIn[3:0]} : 8'h00});
    q2.push_back({1'b1, tk && s[3:0] < 4'h9, s[3:0] == 4'hD, nx, operandA, bankSel, op[2:0],
      bankSel, 2'b00, op[0], cy, op == 8'hD6 ? {ramIn[7:4], accIn[3:0]} : ramIn, ax});
    @(posedge clk) #1;
  endtask

  task automatic chk2(input logic [53:0] ex, input logic [53:0] ac);
    checks_done++;
    if (ac !== ex)
    begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, ex, ac);
    end
  endtask

  task automatic chk(input logic [33:0] ex, input logic [33:0] ac);
    checks_done++;
    if (ac !== ex)
    begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, ex, ac);
    end
  endtask

  always @(posedge clk)
  begin
    if (execDone === 1'b1)
    begin
      e = q.pop_front();
      chk(e[33:0], {lenOut, cyclesOut, cnt, pcRedirect, directIsSfr,
        pcRedirect ? pcTarget : 16'h0000, e[34] ? accOut : 8'h00});
      e2 = q2.pop_front();
      chk2(e2, {instKnown, branchTaken, isReturn, nextPc, directAddr,
        regAddr, ptrRegAddr, carryOut, ramOut, accOut});
    end
    cnt = (instValid && instReady) ? 3'h1 : cnt + 3'h1;
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    {instValid, opcode, operandA, operandB, instPc, bankSel, carryIn} = '0;
    {accIn, ramIn, dptrIn, bitIn, cmpUnequal, decNonzero} = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk) #1;
    foreach (ops[i]) send(ops[i]);
    $display("directed opcode pass done");
    repeat (300) send(ops[rnd() % ops.size()]);
    instValid = 1'b0;
    repeat (8) @(posedge clk);
    chk(34'(q.size()), 34'h0);
    $display("random opcode pass done");
    stop_test();
  end
endmodule
